// ==== hdl/qps_defines.vh ====
// constants for the quad pot serial command slave
`ifndef QPS_DEFINES_VH
`define QPS_DEFINES_VH
// device type code, value arbitrary
`define QPS_TYPE_CODE     4'hA
`define QPS_OP_RD_WIPER   4'h9
`define QPS_OP_WR_WIPER   4'hA
`define QPS_OP_RD_DATA    4'hB
`define QPS_OP_WR_DATA    4'hC
`define QPS_OP_XFR_D2W    4'hD
`define QPS_OP_XFR_W2D    4'hE
`define QPS_OP_GXFR_D2W   4'h1
`define QPS_OP_GXFR_W2D   4'h8
`define QPS_OP_INCDEC     4'h2
`define QPS_POS_MAX       6'h3F
`define QPS_NV_RST_VAL    8'h00
`define QPS_CLK_MHZ       50
`define QPS_NV_WRITE_MS   5
`define QPS_NV_WRITE_CYC  (`QPS_NV_WRITE_MS * 1000 * `QPS_CLK_MHZ)
`define QPS_SETTLE_CYC    3'h4
`endif

// ==== hdl/qps_slave.v ====
// two-wire slave and command decoder for a quad digital pot
// Behaviour
// - data changes only with clock low; changes with clock high are framing
// - start is data fall with clock high; nothing counts before it
// - after eight bits sender releases data; receiver pulls ninth bit low
// - acknowledge address, command, and data byte when one follows
// - address first after start; upper four bits are the type code
// - lower four address bits must equal the strap inputs to acknowledge
// - stop after nonvolatile write starts busy cycle; address not acked
// - master may poll with start and address until acknowledged
// - command byte is opcode, pot select, register select
// - read/write wiper and data opcodes; wiper ops ignore register select
// - transfer, global transfer and increment/decrement opcodes
// - global transfers act on all four pots with one register index
// - transfers finish with the command byte and carry no data
// - data to wiper is a volatile write; taps follow after settling
// - wiper to data is a nonvolatile write with busy time
// - register reads and writes use address, command, one data byte
// - in stepping, clock high pulse with data high moves wiper up
// - in stepping, clock high pulse with data low moves wiper down
// - low six wiper bits select exactly one of 64 taps
// - after reset each wiper loads from its setting zero
// - data byte: position low six bits, bit 6 wiper off, bit 7 cascade
// - any nonvolatile change completes within ten milliseconds
`timescale 1ns/1ns
`default_nettype none
`include "qps_defines.vh"
module qps_slave #(
    parameter NV_WRITE_CYC = `QPS_NV_WRITE_CYC
) (
    input  wire         core_clk,
    input  wire         sys_rst,
    input  wire         scl_in,
    input  wire         sda_in,
    output reg          sda_out,
    output reg          sda_oe,
    input  wire [3:0]   address_strap_inputs,
    output reg  [255:0] tap_select,
    output reg  [3:0]   wiper_off_flag,
    output reg  [3:0]   cascade_flag,
    output reg          nv_busy
);
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_CMD  = 3'd2;
    localparam ST_WDAT = 3'd3;
    localparam ST_RDAT = 3'd4;
    localparam ST_STEP = 3'd5;
    localparam ST_DONE = 3'd6;
    localparam ST_LOAD = 3'd7;

    reg  [1:0]  scl_s_q;
    reg  [1:0]  sda_s_q;
    reg         scl_q;
    reg         sda_q;
    reg  [2:0]  st_q;
    reg  [3:0]  bit_q;
    reg  [7:0]  sh_q;
    reg  [7:0]  cmd_q;
    reg         rd_q;
    reg         nv_pend_q;
    reg  [31:0] busy_q;
    reg  [2:0]  settle_q;
    reg  [1:0]  ld_q;
    reg  [3:0]  strap_m_q;
    reg  [3:0]  strap_q;
    reg  [7:0]  wiper_position_register [0:3];
    reg  [7:0]  nv_mem [0:15];
    integer     i;
    integer     j;

    wire scl_rise = scl_s_q[1] & ~scl_q;
    wire scl_fall = ~scl_s_q[1] & scl_q;
    // framing only when clock stays high across the data edge
    wire start_ev = scl_q & scl_s_q[1] & sda_q & ~sda_s_q[1];
    wire stop_ev  = scl_q & scl_s_q[1] & ~sda_q & sda_s_q[1];
    wire [3:0] op   = cmd_q[7:4];
    wire [1:0] psel = cmd_q[3:2];
    wire [1:0] rsel = cmd_q[1:0];
    wire [3:0] nop  = sh_q[7:4];
    wire [3:0] nidx = {sh_q[3:2], sh_q[1:0]};
    wire [5:0] cur  = wiper_position_register[psel][5:0];
    wire valid_op = (nop == `QPS_OP_RD_WIPER) | (nop == `QPS_OP_WR_WIPER) |
                    (nop == `QPS_OP_RD_DATA)  | (nop == `QPS_OP_WR_DATA)  |
                    (nop == `QPS_OP_XFR_D2W)  | (nop == `QPS_OP_XFR_W2D)  |
                    (nop == `QPS_OP_GXFR_D2W) | (nop == `QPS_OP_GXFR_W2D) |
                    (nop == `QPS_OP_INCDEC);

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // idle-high so release of reset shows no false edge
            scl_s_q <= 2'b11;
            sda_s_q <= 2'b11;
            scl_q   <= 1'b1;
            sda_q   <= 1'b1;
        end else begin
            scl_s_q <= {scl_s_q[0], scl_in};
            sda_s_q <= {sda_s_q[0], sda_in};
            scl_q   <= scl_s_q[1];
            sda_q   <= sda_s_q[1];
        end
    end

    // straps are board pins: two flops before the address compare
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_m_q <= 4'h0;
            strap_q   <= 4'h0;
        end else begin
            strap_m_q <= address_strap_inputs;
            strap_q   <= strap_m_q;
        end
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q      <= ST_LOAD;
            bit_q     <= 4'h0;
            sh_q      <= 8'h00;
            cmd_q     <= 8'h00;
            rd_q      <= 1'b0;
            sda_out   <= 1'b0;
            sda_oe    <= 1'b0;
            nv_pend_q <= 1'b0;
            busy_q    <= 32'd0;
            nv_busy   <= 1'b0;
            ld_q      <= 2'd0;
            settle_q  <= 3'd0;
            for (i = 0; i < 4; i = i + 1)
                wiper_position_register[i] <= 8'h00;
            // no real cells here: the store clears with reset
            for (i = 0; i < 16; i = i + 1)
                nv_mem[i] <= `QPS_NV_RST_VAL;
        end else begin
            if (settle_q != 3'd0)
                settle_q <= settle_q - 3'd1;
            if (busy_q != 32'd0)
                busy_q <= busy_q - 32'd1;
            else
                nv_busy <= 1'b0;
            if (st_q == ST_LOAD) begin
                // reset load: one pot per cycle from its setting zero
                wiper_position_register[ld_q] <= nv_mem[{ld_q, 2'b00}];
                ld_q <= ld_q + 2'd1;
                if (ld_q == 2'd3)
                    st_q <= ST_IDLE;
            end else if (stop_ev) begin
                st_q   <= ST_IDLE;
                sda_oe <= 1'b0;
                rd_q   <= 1'b0;
                if (nv_pend_q) begin
                    nv_pend_q <= 1'b0;
                    nv_busy   <= 1'b1;
                    // flag drops one cycle after the count reaches zero
                    busy_q    <= NV_WRITE_CYC;
                end
            end else if (start_ev) begin
                st_q      <= ST_ADDR;
                bit_q     <= 4'h0;
                // an aborted read must not leave the drive path armed
                rd_q      <= 1'b0;
                sda_oe    <= 1'b0;
                nv_pend_q <= 1'b0;
            end else if (st_q == ST_STEP) begin
                if (scl_fall && bit_q == 4'h9) begin
                    // command ack pulse over: free the line, then step
                    sda_oe <= 1'b0;
                    bit_q  <= 4'h0;
                end else if (scl_rise && bit_q != 4'h9) begin
                    // ends hold rather than wrap
                    if (sda_q && cur != `QPS_POS_MAX)
                        wiper_position_register[psel][5:0] <= cur + 6'd1;
                    else if (!sda_q && cur != 6'd0)
                        wiper_position_register[psel][5:0] <= cur - 6'd1;
                end
            end else if (st_q != ST_IDLE && st_q != ST_DONE) begin
                // while sending a read byte the line carries our own bits
                if (scl_rise && !rd_q && bit_q < 4'd8) begin
                    sh_q  <= {sh_q[6:0], sda_q};
                    bit_q <= bit_q + 4'd1;
                end
                if (scl_fall && bit_q == 4'd9) begin
                    sda_oe <= 1'b0;
                    bit_q  <= 4'h0;
                    if (rd_q) begin
                        rd_q    <= 1'b0;
                        st_q    <= ST_DONE;
                    end else if (st_q == ST_RDAT) begin
                        sda_oe  <= ~sh_q[7];
                        sda_out <= 1'b0;
                        sh_q    <= {sh_q[6:0], 1'b0};
                        bit_q   <= 4'd1;
                        rd_q    <= 1'b1;
                    end
                    if (st_q == ST_CMD) begin
                        sda_oe  <= 1'b0;
                        rd_q    <= 1'b0;
                    end
                end else if (scl_fall && rd_q && bit_q < 4'd8) begin
                    // drive next read bit; release equals high
                    sda_oe <= ~sh_q[7];
                    sh_q   <= {sh_q[6:0], 1'b0};
                    bit_q  <= bit_q + 4'd1;
                end else if (scl_fall && rd_q && bit_q == 4'd8) begin
                    sda_oe <= 1'b0;                           // master acks
                    bit_q  <= 4'd9;
                end else if (scl_fall && !rd_q && bit_q == 4'd8) begin
                    bit_q <= 4'd9;
                    case (st_q)
                    // polling during a write cycle gets no ack
                    ST_ADDR: begin
                        if (sh_q[7:4] == `QPS_TYPE_CODE &&
                            sh_q[3:0] == strap_q &&
                            !nv_busy) begin
                            sda_oe <= 1'b1;
                            st_q   <= ST_CMD;
                        end else
                            st_q <= ST_IDLE;
                    end
                    ST_CMD: begin
                        cmd_q <= sh_q;
                        if (!valid_op)
                            st_q <= ST_IDLE;
                        else begin
                            sda_oe <= 1'b1;
                            case (nop)
                            `QPS_OP_RD_WIPER, `QPS_OP_RD_DATA: begin
                                st_q <= ST_RDAT;
                                sh_q <= (nop == `QPS_OP_RD_WIPER) ?
                                    wiper_position_register[sh_q[3:2]] :
                                    nv_mem[nidx];
                            end
                            `QPS_OP_WR_WIPER, `QPS_OP_WR_DATA:
                                st_q <= ST_WDAT;
                            `QPS_OP_INCDEC:
                                st_q <= ST_STEP;
                            `QPS_OP_XFR_D2W: begin
                                wiper_position_register[sh_q[3:2]] <= nv_mem[nidx];
                                settle_q <= `QPS_SETTLE_CYC;
                                st_q <= ST_DONE;
                            end
                            `QPS_OP_XFR_W2D: begin
                                nv_mem[nidx] <= wiper_position_register[sh_q[3:2]];
                                nv_pend_q <= 1'b1;
                                st_q <= ST_DONE;
                            end
                            `QPS_OP_GXFR_D2W: begin
                                for (i = 0; i < 4; i = i + 1)
                                    wiper_position_register[i] <=
                                        nv_mem[{i[1:0], sh_q[1:0]}];
                                settle_q <= `QPS_SETTLE_CYC;
                                st_q <= ST_DONE;
                            end
                            default: begin
                                for (i = 0; i < 4; i = i + 1)
                                    nv_mem[{i[1:0], sh_q[1:0]}] <=
                                        wiper_position_register[i];
                                nv_pend_q <= 1'b1;
                                st_q <= ST_DONE;
                            end
                            endcase
                        end
                    end
                    ST_WDAT: begin
                        sda_oe <= 1'b1;
                        st_q   <= ST_DONE;
                        if (op == `QPS_OP_WR_WIPER) begin
                            wiper_position_register[psel] <= sh_q;
                            settle_q <= `QPS_SETTLE_CYC;
                        end else begin
                            nv_mem[{psel, rsel}] <= sh_q;
                            nv_pend_q <= 1'b1;
                        end
                    end
                    default: st_q <= ST_IDLE;
                    endcase
                end
            end else if (st_q == ST_DONE && scl_fall && bit_q == 4'd9) begin
                sda_oe <= 1'b0;
                bit_q  <= 4'h0;
            end
        end
    end

    // tap decode waits for settling after a parallel or serial load
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tap_select     <= 256'd0;
            wiper_off_flag <= 4'h0;
            cascade_flag   <= 4'h0;
        end else if (settle_q == 3'd0 || settle_q == 3'd1) begin
            for (j = 0; j < 4; j = j + 1) begin
                tap_select[j*64 +: 64] <= 64'd1 <<
                    wiper_position_register[j][5:0];
                wiper_off_flag[j] <= wiper_position_register[j][6];
                cascade_flag[j]   <= wiper_position_register[j][7];
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/qps_slave_sva.sv ====
// assertions on the pot slave ports
`timescale 1ns/1ns
`default_nettype none
module qps_slave_sva #(
    parameter NV_WRITE_CYC = 100
) (
    input wire logic         core_clk,
    input wire logic         sys_rst,
    input wire logic         scl_in,
    input wire logic         sda_in,
    input wire logic         sda_out,
    input wire logic         sda_oe,
    input wire logic [3:0]   address_strap_inputs,
    input wire logic [255:0] tap_select,
    input wire logic [3:0]   wiper_off_flag,
    input wire logic [3:0]   cascade_flag,
    input wire logic         nv_busy
);
    // the cycle at a count of zero adds one to the busy time
    localparam int BUSY_LEN = NV_WRITE_CYC + 1;
    logic [3:0]  up_q;
    logic [31:0] bz_q;
    // age since reset; taps are loading in the first cycles
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            up_q <= 4'h0;
            bz_q <= 32'h0;
        end else begin
            up_q <= (up_q == 4'hF) ? up_q : up_q + 4'h1;
            bz_q <= nv_busy ? bz_q + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence rst_gone;
        $fell(sys_rst);
    endsequence
    sequence oe_up;
        $rose(sda_oe);
    endsequence
    sda_out_low_a: assert property (sda_out == 1'b0)
        else $error("data out not low");
    ack_edge_a: assert property (oe_up |-> !$past(scl_in, 2))
        else $error("pull started with clock high");
    oe_release_a: assert property (oe_up |-> ##[1:90] !sda_oe)
        else $error("data line held too long");
    busy_quiet_a: assert property (nv_busy |-> !sda_oe)
        else $error("answer while busy");
    busy_len_a: assert property ($fell(nv_busy) |-> bz_q == BUSY_LEN)
        else $error("busy length wrong");
    rst_clear_a: assert property (rst_gone |-> tap_select == 256'h0 && !nv_busy)
        else $error("outputs not clear in reset");
    tap_load_a: assert property (rst_gone |-> ##[2:8] tap_select == {4{64'h1}})
        else $error("taps not loaded after reset");
    tap_onehot_a: assert property (up_q == 4'hF |->
        $onehot(tap_select[63:0]) && $onehot(tap_select[127:64]) &&
        $onehot(tap_select[191:128]) && $onehot(tap_select[255:192]))
        else $error("taps not one-hot");
endmodule
bind qps_slave qps_slave_sva #(.NV_WRITE_CYC(NV_WRITE_CYC)) u_sva (
    .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap_inputs(address_strap_inputs), .tap_select(tap_select),
    .wiper_off_flag(wiper_off_flag), .cascade_flag(cascade_flag),
    .nv_busy(nv_busy));
`default_nettype wire

// ==== verif/qps_master_model.sv ====
// two-wire bus master model for the pot slave
`timescale 1ns/1ns
`default_nettype none
module qps_master_model (
    input  wire logic core_clk,
    input  wire logic sda_line,
    output var  logic scl,
    output var  logic sda_low
);
    // clock stands high and data released between frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic q;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    // master alone clocks; data set mid-low
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        q();
        sda_low = !b;
        q();
        scl = 1'b1;
        q();
        q();
        r = sda_line;
    endtask
    // start when is_stop low, stop otherwise
    task automatic mark(input logic is_stop);
        scl = 1'b0;
        q();
        sda_low = is_stop;
        q();
        scl = 1'b1;
        q();
        sda_low = !is_stop;
        q();
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
        bit_io(1'b1, ack);
        ack = !ack;
    endtask
    // line left released on the ninth pulse: no acknowledge
    task automatic rd_byte(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
    endtask
endmodule
`default_nettype wire

// ==== verif/test_quad_pot_serial_command_slave.sv ====
// self-checking bench for the pot serial slave
`timescale 1ns/1ns
`default_nettype none
`include "qps_defines.vh"
module test_quad_pot_serial_command_slave;
    logic         core_clk;
    logic         sys_rst;
    logic [3:0]   straps;
    logic         scl, sda_low, sda_out, sda_oe, nv_busy, ok;
    wire          sda_line = !(sda_low || sda_oe);
    logic [255:0] tap_select;
    logic [3:0]   wiper_off_flag, cascade_flag;
    logic [7:0]   wip [4];
    logic [7:0]   dat [16];
    logic [31:0]  seed;
    logic [31:0]  v;
    int           failures = 0;
    int           checks = 0;
    int           cyc = 0;
    qps_slave #(.NV_WRITE_CYC(100)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_strap_inputs(straps), .tap_select(tap_select),
        .wiper_off_flag(wiper_off_flag), .cascade_flag(cascade_flag),
        .nv_busy(nv_busy));
    qps_master_model m (.core_clk(core_clk), .sda_line(sda_line),
        .scl(scl), .sda_low(sda_low));
    always #10 core_clk = !core_clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [255:0] taps();
        logic [255:0] t;
        t = 256'h0;
        for (int p = 0; p < 4; p++) t[p * 64 + wip[p][5:0]] = 1'b1;
        return t;
    endfunction
    function automatic logic [7:0] flg();
        for (int p = 0; p < 4; p++) flg[p] = wip[p][6];
        for (int p = 0; p < 4; p++) flg[p + 4] = wip[p][7];
    endfunction
    task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] c, output logic ack);
        logic a;
        m.mark(1'b0);
        m.wr_byte({`QPS_TYPE_CODE, straps}, a);
        m.wr_byte(c, ack);
        ack = ack && a;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        logic a;
        cmd(c, a);
        m.wr_byte(d, ok);
        m.mark(1'b1);
        chk(a && ok, 1'b1);
    endtask
    task automatic rd(input logic [7:0] c, input logic [7:0] e);
        logic [7:0] d;
        cmd(c, ok);
        m.rd_byte(d);
        m.mark(1'b1);
        chk({ok, d}, {1'b1, e});
    endtask
    task automatic transfer_op(input logic [7:0] c);
        cmd(c, ok);
        m.mark(1'b1);
        chk(ok, 1'b1);
    endtask
    // settle allowance covers sync latency plus wiper settling
    task automatic look;
        repeat (8) @(posedge core_clk);
        #1;
        chk(tap_select, taps());
        chk({cascade_flag, wiper_off_flag}, flg());
    endtask
    task automatic nv_wait;
        logic a;
        repeat (4) @(posedge core_clk);
        #1;
        chk(nv_busy, 1'b1);
        for (int i = 0; i < 20; i++) begin
            m.mark(1'b0);
            m.wr_byte({`QPS_TYPE_CODE, straps}, a);
            m.mark(1'b1);
            if (i == 0) chk(a, 1'b0);
            if (a) break;
        end
        chk(a, 1'b1);
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        core_clk = 1'b0;
        sys_rst = 1'b1;
        straps = 4'h6;
        seed = 32'h8383;
        foreach (wip[i]) wip[i] = 8'h00;
        foreach (dat[i]) dat[i] = 8'h00;
        repeat (4) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        look();
        m.mark(1'b0);
        m.wr_byte({`QPS_TYPE_CODE, ~straps}, ok);
        m.mark(1'b1);
        chk(ok, 1'b0);
        m.mark(1'b0);
        m.wr_byte({~`QPS_TYPE_CODE, straps}, ok);
        m.mark(1'b1);
        chk(ok, 1'b0);
        cmd(8'h3C, ok);
        m.mark(1'b1);
        chk(ok, 1'b0);
        for (int i = 0; i < 6; i++) begin
            v = rnd();
            straps = v[19:16];
            wr({`QPS_OP_WR_WIPER, v[3:0]}, v[15:8]);
            wip[v[3:2]] = v[15:8];
            look();
            rd({`QPS_OP_RD_WIPER, v[3:2], v[5:4]}, v[15:8]);
        end
        for (int i = 0; i < 3; i++) begin
            v = rnd();
            wr({`QPS_OP_WR_DATA, v[3:0]}, v[15:8]);
            nv_wait();
            rd({`QPS_OP_RD_DATA, v[3:0]}, v[15:8]);
            transfer_op({`QPS_OP_XFR_D2W, v[3:0]});
            wip[v[3:2]] = v[15:8];
            look();
            transfer_op({`QPS_OP_XFR_W2D, v[3:2], ~v[1:0]});
            nv_wait();
            rd({`QPS_OP_RD_DATA, v[3:2], ~v[1:0]}, v[15:8]);
        end
        v = rnd();
        transfer_op({`QPS_OP_GXFR_W2D, v[3:2], 2'h2});
        nv_wait();
        rd({`QPS_OP_RD_DATA, 4'h6}, wip[1]);
        wr({`QPS_OP_WR_WIPER, 4'h0}, v[15:8]);
        wr({`QPS_OP_WR_WIPER, 4'hC}, v[23:16]);
        transfer_op({`QPS_OP_GXFR_D2W, v[5:4], 2'h2});
        look();
        // stepping past the ends also absorbs the closing pulse
        wr({`QPS_OP_WR_WIPER, 4'h4}, 8'h3D);
        cmd({`QPS_OP_INCDEC, 4'h4}, ok);
        chk(ok, 1'b1);
        repeat (4) m.bit_io(1'b1, ok);
        m.mark(1'b0);
        m.mark(1'b1);
        wip[1] = 8'h3F;
        look();
        wr({`QPS_OP_WR_WIPER, 4'h8}, 8'h42);
        cmd({`QPS_OP_INCDEC, 4'h8}, ok);
        repeat (4) m.bit_io(1'b0, ok);
        m.mark(1'b1);
        wip[2] = 8'h40;
        look();
        end_sim();
    end
endmodule
`default_nettype wire
